// *** design/pio_pkg.sv ***
// Package of register offsets, field positions and reset values for the parallel I/O block
package pio_pkg;
  // Printed offsets are not all multiples of four: these are indices, byte address = 4 * index
  localparam logic [3:0] IDX_PORT_A_DATA = 4'h0;
  localparam logic [3:0] IDX_PORT_B_DATA = 4'h1;
  localparam logic [3:0] IDX_PORT_C_DATA = 4'h2;
  localparam logic [3:0] IDX_INPUT_PORT_DATA = 4'h3;
  localparam logic [3:0] IDX_PORT_A_DIRECTION = 4'h4;
  localparam logic [3:0] IDX_PORT_B_DIRECTION = 4'h5;
  localparam logic [3:0] IDX_PORT_C_DIRECTION = 4'h6;
  localparam logic [3:0] IDX_CLOCK_OUT_CONTROL = 4'h7;
  localparam logic [3:0] IDX_CONVERTER_CONTROL = 4'h9;
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = 4;
  // Field positions
  localparam int CLOCK_OUT_SELECT_BIT = 3;
  localparam int CLOCK_OUT_PIN_BIT = 2;
  localparam int CONVERTER_ON_BIT = 5;
  localparam logic [7:0] CLOCK_OUT_CTRL_MASK = 8'h08;
  localparam logic [7:0] CONVERTER_CTRL_MASK = 8'h6F;
  // Reset values
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] LATCH_POWER_UP = 8'h00;
endpackage

// *** design/pio_ports.sv ***
// Parallel I/O ports: three bidirectional ports, one input-only port, clock out, APB slave
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module pio_ports #(
  parameter int PORT_W = 8,
  parameter bit PULL_DOWN_B = 1'b0,
  parameter bit PULL_DOWN_C = 1'b0
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [PORT_W-1:0] port_a_in,
  output logic [PORT_W-1:0] port_a_out,
  output logic [PORT_W-1:0] port_a_oe_out,
  input wire logic [PORT_W-1:0] port_b_in,
  output logic [PORT_W-1:0] port_b_out,
  output logic [PORT_W-1:0] port_b_oe_out,
  output logic [PORT_W-1:0] port_b_pull_down_out,
  input wire logic [PORT_W-1:0] port_c_in,
  output logic [PORT_W-1:0] port_c_out,
  output logic [PORT_W-1:0] port_c_oe_out,
  output logic [PORT_W-1:0] port_c_pull_down_out,
  input wire logic [PORT_W-1:0] shared_input_pins_in,
  input wire logic internal_bus_clock_in,
  input wire logic wired_or_irq_enable_in,
  output logic wired_or_irq_out,
  output logic converter_on_out,
  output logic [PORT_W-1:0] converter_control_out
);

  if (PORT_W != 8) begin : g_bad_width
    $error("pio_ports supports only 8-bit ports");
  end

  logic [PORT_W-1:0] port_a_data_ff;
  logic [PORT_W-1:0] port_b_data_ff;
  logic [PORT_W-1:0] port_c_data_ff;
  logic [PORT_W-1:0] port_a_direction_ff;
  logic [PORT_W-1:0] port_b_direction_ff;
  logic [PORT_W-1:0] port_c_direction_ff;
  logic [PORT_W-1:0] clock_out_ctrl_ff;
  logic [PORT_W-1:0] converter_ctrl_ff;
  logic [31:0] prdata_ff;

  wire [pio_pkg::IDX_W-1:0] reg_idx = paddr_in[pio_pkg::ADDR_LSB +: pio_pkg::IDX_W];
  wire addr_upper_zero = (paddr_in[31:pio_pkg::ADDR_LSB+pio_pkg::IDX_W] == '0)
    && (paddr_in[pio_pkg::ADDR_LSB-1:0] == 2'h0);
  wire setup = psel_in && !penable_in;
  wire access = psel_in && penable_in;
  wire byte0_wr = access && pwrite_in && pstrb_in[0];

  wire hit_a_data = addr_upper_zero && (reg_idx == pio_pkg::IDX_PORT_A_DATA);
  wire hit_b_data = addr_upper_zero && (reg_idx == pio_pkg::IDX_PORT_B_DATA);
  wire hit_c_data = addr_upper_zero && (reg_idx == pio_pkg::IDX_PORT_C_DATA);
  wire hit_in_data = addr_upper_zero && (reg_idx == pio_pkg::IDX_INPUT_PORT_DATA);
  wire hit_a_dir = addr_upper_zero && (reg_idx == pio_pkg::IDX_PORT_A_DIRECTION);
  wire hit_b_dir = addr_upper_zero && (reg_idx == pio_pkg::IDX_PORT_B_DIRECTION);
  wire hit_c_dir = addr_upper_zero && (reg_idx == pio_pkg::IDX_PORT_C_DIRECTION);
  wire hit_clk_ctrl = addr_upper_zero && (reg_idx == pio_pkg::IDX_CLOCK_OUT_CONTROL);
  wire hit_conv_ctrl = addr_upper_zero && (reg_idx == pio_pkg::IDX_CONVERTER_CONTROL);
  wire hit_any = hit_a_data || hit_b_data || hit_c_data || hit_in_data || hit_a_dir
    || hit_b_dir || hit_c_dir || hit_clk_ctrl || hit_conv_ctrl;
  // Writing the read-only input port is refused with an error
  wire bad_access = !hit_any || (pwrite_in && hit_in_data);

  wire clock_out_select = clock_out_ctrl_ff[pio_pkg::CLOCK_OUT_SELECT_BIT];
  wire [PORT_W-1:0] clk_pin_mask = PORT_W'(1) << pio_pkg::CLOCK_OUT_PIN_BIT;

  wire [PORT_W-1:0] port_c_dir_eff = clock_out_select ?
    (port_c_direction_ff | clk_pin_mask) : port_c_direction_ff;

  assign port_a_oe_out = port_a_direction_ff;
  assign port_b_oe_out = port_b_direction_ff;
  assign port_c_oe_out = port_c_dir_eff;
  assign port_a_out = port_a_data_ff;
  assign port_b_out = port_b_data_ff;
  for (genvar b = 0; b < PORT_W; b++) begin : g_pc_out
    assign port_c_out[b] = (clock_out_select && (b == pio_pkg::CLOCK_OUT_PIN_BIT)) ?
      internal_bus_clock_in : port_c_data_ff[b];
  end

  assign port_b_pull_down_out = PULL_DOWN_B ? ~port_b_direction_ff : '0;
  assign port_c_pull_down_out = PULL_DOWN_C ? ~port_c_dir_eff : '0;

  assign wired_or_irq_out = wired_or_irq_enable_in && |(port_b_in & ~port_b_direction_ff);

  assign converter_on_out = converter_ctrl_ff[pio_pkg::CONVERTER_ON_BIT];
  assign converter_control_out = converter_ctrl_ff;

  wire [PORT_W-1:0] a_view = (port_a_direction_ff & port_a_data_ff)
    | (~port_a_direction_ff & port_a_in);
  wire [PORT_W-1:0] b_view = (port_b_direction_ff & port_b_data_ff)
    | (~port_b_direction_ff & port_b_in);
  wire [PORT_W-1:0] c_view = (port_c_dir_eff & port_c_data_ff) | (~port_c_dir_eff & port_c_in);

  logic [PORT_W-1:0] rd_byte;
  always_comb begin
    rd_byte = '0;
    if (hit_a_data) begin
      rd_byte = a_view;
    end else if (hit_b_data) begin
      rd_byte = b_view;
    end else if (hit_c_data) begin
      rd_byte = c_view;
    end else if (hit_in_data) begin
      rd_byte = shared_input_pins_in;
    end else if (hit_a_dir) begin
      rd_byte = port_a_direction_ff;
    end else if (hit_b_dir) begin
      rd_byte = port_b_direction_ff;
    end else if (hit_c_dir) begin
      rd_byte = port_c_dir_eff;
    end else if (hit_clk_ctrl) begin
      rd_byte = clock_out_ctrl_ff;
    end else if (hit_conv_ctrl) begin
      rd_byte = converter_ctrl_ff;
    end
  end

  assign pready_out = 1'b1;
  assign pslverr_out = access && bad_access;
  assign prdata_out = prdata_ff;

  // Read data captured in setup so it is stable during the access phase
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup && !pwrite_in) begin
      prdata_ff <= {{(32-PORT_W){1'b0}}, rd_byte};
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_a_direction_ff <= pio_pkg::DIRECTION_RESET;
      port_b_direction_ff <= pio_pkg::DIRECTION_RESET;
      port_c_direction_ff <= pio_pkg::DIRECTION_RESET;
      clock_out_ctrl_ff <= pio_pkg::CONTROL_RESET;
      converter_ctrl_ff <= pio_pkg::CONTROL_RESET;
    end else if (byte0_wr) begin
      if (hit_a_dir) begin
        port_a_direction_ff <= pwdata_in[PORT_W-1:0];
      end
      if (hit_b_dir) begin
        port_b_direction_ff <= pwdata_in[PORT_W-1:0];
      end
      if (hit_c_dir) begin
        port_c_direction_ff <= pwdata_in[PORT_W-1:0];
      end
      if (hit_clk_ctrl) begin
        clock_out_ctrl_ff <= pwdata_in[PORT_W-1:0] & pio_pkg::CLOCK_OUT_CTRL_MASK;
      end
      if (hit_conv_ctrl) begin
        converter_ctrl_ff <= pwdata_in[PORT_W-1:0] & pio_pkg::CONVERTER_CTRL_MASK;
      end
    end
  end

  // latches take no reset, so they keep their value across it
  always_ff @(posedge clock_in) begin
    if (byte0_wr && hit_a_data) begin
      port_a_data_ff <= pwdata_in[PORT_W-1:0];
    end
    if (byte0_wr && hit_b_data) begin
      port_b_data_ff <= pwdata_in[PORT_W-1:0];
    end
    if (byte0_wr && hit_c_data) begin
      port_c_data_ff <= pwdata_in[PORT_W-1:0];
    end
  end

endmodule // pio_ports

// *** test/pio_board.sv ***
// Board circuitry on one bidirectional port
`timescale 1ns/1ps
module pio_board (
  input wire logic [7:0] out_in,
  input wire logic [7:0] oe_in,
  input wire logic [7:0] pull_in,
  input wire logic [7:0] ext_in,
  output logic [7:0] pin_out
);
  // Driven pins show the latch, pulled inputs read low, the rest the board level
  assign pin_out = (oe_in & out_in) | (~oe_in & ~pull_in & ext_in);
endmodule // pio_board

// *** test/pio_ports_bench.sv ***
// Self-checking bench of the parallel I/O ports
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module pio_ports_bench;
  logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, ibc = 0, woe = 0, rdy, err, e, irq, con;
  logic [31:0] paddr = 0, pwdata = 0, prd, r;
  logic [7:0] ext = 8'h00, sh = 8'h00, ao, aoe, bo, boe, bpd, co, coe, cpd, ap, bp, cp, cc;
  int n_errors = 0, n_compared = 0, cyc = 0;
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) ibc <= ~ibc;
  pio_ports u_dut (.clock_in(clk), .nrst_in(nrst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF),
    .prdata_out(prd), .pready_out(rdy), .pslverr_out(err), .port_a_in(ap), .port_a_out(ao),
    .port_a_oe_out(aoe), .port_b_in(bp), .port_b_out(bo), .port_b_oe_out(boe),
    .port_b_pull_down_out(bpd), .port_c_in(cp), .port_c_out(co), .port_c_oe_out(coe),
    .port_c_pull_down_out(cpd), .shared_input_pins_in(sh), .internal_bus_clock_in(ibc),
    .wired_or_irq_enable_in(woe), .wired_or_irq_out(irq), .converter_on_out(con),
    .converter_control_out(cc));
  pio_board u_a (.out_in(ao), .oe_in(aoe), .pull_in(8'h00), .ext_in(ext), .pin_out(ap));
  pio_board u_b (.out_in(bo), .oe_in(boe), .pull_in(bpd), .ext_in(ext), .pin_out(bp));
  pio_board u_c (.out_in(co), .oe_in(coe), .pull_in(cpd), .ext_in(ext), .pin_out(cp));
  task automatic end_of_test();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic xfer(input logic w, input logic [3:0] i, input logic [7:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {26'h0, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    r = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [3:0] i, input logic [7:0] x);
    xfer(1'b0, i, 8'h00);
    `CHK("read data", x, r[7:0])
  endtask
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 4; i < 8; i++) rdc(4'(i), 8'h00);
    rdc(4'h9, 8'h00);
    $display("reset test done");
    ext <= 8'h5A;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, 4'(i), 8'hA5);
      rdc(4'(i), 8'h5A);
      xfer(1'b1, 4'(i + 4), 8'hFF);
      `CHK("pins", 8'hA5, (i == 0) ? ap : (i == 1) ? bp : cp)
      rdc(4'(i), 8'hA5);
      rdc(4'(i + 4), 8'hFF);
      xfer(1'b1, 4'(i + 4), 8'h00);
    end
    $display("port test done");
    sh <= 8'h3C;
    rdc(4'h3, 8'h3C);
    xfer(1'b1, 4'h3, 8'hFF);
    `CHK("input write error", 1'b1, e)
    xfer(1'b1, 4'h9, 8'h20);
    `CHK("converter on", 1'b1, con)
    `CHK("converter control", 8'h20, cc)
    `CHK("pull b", 8'h00, bpd)
    `CHK("pull c", 8'h00, cpd)
    rdc(4'h3, 8'h3C);
    ext <= 8'h01;
    woe <= 1'b1;
    @(posedge clk);
    `CHK("irq", 1'b1, irq)
    xfer(1'b1, 4'h5, 8'h01);
    `CHK("irq", 1'b0, irq)
    $display("input and irq test done");
    xfer(1'b1, 4'h7, 8'h08);
    `CHK("clock oe", 8'h04, coe)
    `CHK("clock out", ibc, co[2])
    rdc(4'h6, 8'h04);
    xfer(1'b1, 4'h6, 8'h01);
    `CHK("other c oe", 8'h05, coe)
    xfer(1'b1, 4'h8, 8'h55);
    `CHK("unmapped error", 1'b1, e)
    $display("clock out test done");
    xfer(1'b1, 4'h0, 8'h3C);
    xfer(1'b1, 4'h4, 8'hFF);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    `CHK("latch kept", 8'h3C, ao)
    `CHK("a oe reset", 8'h00, aoe)
    `CHK("clock out reset", 8'h00, coe)
    $display("second reset test done");
    end_of_test();
  end
endmodule // pio_ports_bench

// *** test/pio_ports_sva.sv ***
// Concurrent checks of the parallel I/O ports
`timescale 1ns/1ps
module pio_ports_chk #(
  parameter int PORT_W = 8
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [PORT_W-1:0] port_a_out,
  input wire logic [PORT_W-1:0] port_a_oe_out,
  input wire logic [PORT_W-1:0] port_b_in,
  input wire logic [PORT_W-1:0] port_b_oe_out,
  input wire logic [PORT_W-1:0] port_c_out,
  input wire logic [PORT_W-1:0] port_c_oe_out,
  input wire logic [PORT_W-1:0] shared_input_pins_in,
  input wire logic internal_bus_clock_in,
  input wire logic wired_or_irq_enable_in,
  input wire logic wired_or_irq_out
);
  wire wr = psel_in & penable_in & pwrite_in & pstrb_in[0];
  wire acc = psel_in & penable_in;
  wire [3:0] idx = paddr_in[5:2];
  logic sel_ff;
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) sel_ff <= 1'b0;
    else if (wr && idx == 4'h7) sel_ff <= pwdata_in[3];
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  a_dir_reset:
    assert property ($rose(nrst_in) |-> (port_a_oe_out | port_b_oe_out | port_c_oe_out) == '0)
    else $error("direction not cleared by reset");
  a_ready_now:
    assert property (acc |-> pready_out) else $error("access not completed at once");
  a_dir_write:
    assert property (wr && idx == 4'h4 |=> port_a_oe_out == $past(pwdata_in[7:0]))
    else $error("direction write not on pins");
  a_latch_write:
    assert property (wr && idx == 4'h0 |=> port_a_out == $past(pwdata_in[7:0]))
    else $error("latch write lost");
  a_clock_out:
    assert property (sel_ff |-> port_c_oe_out[2] && port_c_out[2] == internal_bus_clock_in)
    else $error("clock not on output pin");
  a_wired_or:
    assert property (wired_or_irq_out == (wired_or_irq_enable_in
      && |(port_b_in & ~port_b_oe_out))) else $error("wired-or request wrong");
  a_input_refuse:
    assert property (acc && pwrite_in && idx == 4'h3 |-> pslverr_out)
    else $error("input port write accepted");
  a_input_read:
    assert property (psel_in && !penable_in && !pwrite_in && idx == 4'h3
      |=> prdata_out[7:0] == $past(shared_input_pins_in)) else $error("input read wrong");
  c_clock_out: cover property (sel_ff);
  c_irq: cover property (wired_or_irq_out);
  c_refuse: cover property (pslverr_out);
endmodule // pio_ports_chk
bind pio_ports pio_ports_chk #(.PORT_W(PORT_W)) u_chk (.*);
